/* File: dac_serial_pkg.sv */
// Shared constants and types for the quad converter serial write port.
// Assumes a single system clock domain; the serial pins are sampled by it.
package dac_serial_pkg;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam int FRAME_BITS  = 16;
  localparam int ADDR_MSB    = 15;
  localparam int ADDR_LSB    = 14;
  localparam int MODE_MSB    = 13;
  localparam int MODE_LSB    = 12;
  localparam int CODE_MSB    = 11;
  localparam int CODE_LSB    = 2;
  localparam int CODE_WIDTH  = 10;
  localparam int CHANNELS    = 4;
  localparam logic [4:0] LAST_BIT_INDEX = 5'h0F;

  // ==========================================================================
  // Operating modes
  // ==========================================================================
  localparam logic [1:0] MODE_WRITE_HOLD       = 2'h0;
  localparam logic [1:0] MODE_WRITE_UPDATE     = 2'h1;
  localparam logic [1:0] MODE_WRITE_ALL_UPDATE = 2'h2;
  localparam logic [1:0] MODE_POWER_DOWN       = 2'h3;

  // ==========================================================================
  // Reset values and buffering
  // ==========================================================================
  localparam logic [CODE_WIDTH-1:0] CODE_RESET = 10'h000;
  localparam logic [CODE_WIDTH-1:0] CODE_FULL  = 10'h3FF;
  localparam int FIFO_DEPTH    = 16;
  localparam int SYNC_STAGES   = 3;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } frame_state_type;

endpackage

/* File: pin_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes every input bit comes from outside the clk_sys domain.
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_type;

  sync_state_type r_q;
  sync_state_type r_d;

  // ==========================================================================
  // Filter: a change counts once stages two and three agree
  // ==========================================================================
  always_comb begin
    r_d    = r_q;
    r_d.s1 = pin_in;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) begin
        r_d.level[i] = r_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign level_q = r_q.level;

endmodule // pin_sync

/* File: word_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
// Assumes both sides run on clk_sys; DEPTH is a power of two.
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } fifo_state_type;

  fifo_state_type r_q;
  fifo_state_type r_d;
  logic           push;
  logic           pop;

  // ==========================================================================
  // Storage and pointers
  // ==========================================================================
  always_comb begin
    r_d  = r_q;
    push = in_valid && (r_q.count != (AW+1)'(DEPTH));
    pop  = out_ready && (r_q.count != '0);
    if (push) begin
      r_d.mem[r_q.wr] = in_data;
      r_d.wr          = r_q.wr + 1'b1;
    end
    if (pop) begin
      r_d.rd = r_q.rd + 1'b1;
    end
    if (push && !pop) begin
      r_d.count = r_q.count + 1'b1;
    end else if (pop && !push) begin
      r_d.count = r_q.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign in_ready  = (r_q.count != (AW+1)'(DEPTH));
  assign out_valid = (r_q.count != '0);
  assign out_data  = r_q.mem[r_q.rd];

endmodule // word_fifo

/* File: quad_dac_serial_write_port.sv */
// Serial write port and channel code registers of a quad 10-bit converter.
// Assumes the serial clock, frame select and data pins are asynchronous to
// clk_sys and much slower than it; srst stands in for the power-on reset.
//
// Notes on behaviour
// - Frame starts on falling frame select only.
// - Shift data on serial clock falls while selected.
// - Sixteenth fall completes frame and runs function; here it is queued, run while apply_hold is low, dropped if FIFO is full.
// - Select may stay low or rise afterward.
// - Extra clocks after sixteenth are ignored.
// - Ten-bit straight binary code per channel.
// - Code 3FF full scale, 000 zero.
// - Leaving power-down starts wake from completion; here wake starts when the queued frame runs.
// - Frame: address, mode, data, MSB first.
// - Four modes: hold, update, all, power-down.
`timescale 1ns/1ns
module quad_dac_serial_write_port (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       sclk,
  input  wire logic       frame_sel_n,
  input  wire logic       sdata,
  input  wire logic       apply_hold,
  output logic [3:0][9:0] channel_code_q,
  output logic [3:0]      powered_down_q,
  output logic [3:0]      wake_start_q,
  output logic [3:0]      full_scale_q,
  output logic            frame_done_q,
  output logic            frame_drop_q,
  output logic            accept_ready_q
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    dac_serial_pkg::frame_state_type st;
    logic [4:0]                      bit_idx;
    logic [15:0]                     shreg;
    logic                            sclk_prev;
    logic                            fsel_prev;
    logic                            push;
    logic [15:0]                     push_word;
    logic [3:0][9:0]                 hold;
    logic [3:0][9:0]                 out;
    logic [3:0]                      pd;
    logic [3:0]                      wake;
    logic [3:0]                      full;
    logic                            done;
    logic                            drop;
    logic                            rdy;
  } port_state_type;

  port_state_type r_q;
  port_state_type r_d;

  logic [2:0]  pins_f;
  logic        sclk_f;
  logic        fsel_n_f;
  logic        sdata_f;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [15:0] fifo_out_data;
  logic        sclk_fall;
  logic        fsel_fall;
  logic [1:0]  w_addr;
  logic [1:0]  w_mode;
  logic [9:0]  w_code;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  pin_sync #(
    .WIDTH (dac_serial_pkg::SYNC_STAGES)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .pin_in  ({sclk, frame_sel_n, sdata}),
    .level_q (pins_f)
  );

  assign sclk_f   = pins_f[2];
  assign fsel_n_f = pins_f[1];
  assign sdata_f  = pins_f[0];

  // ==========================================================================
  // Frame buffer between the serial side and the channel registers
  // ==========================================================================
  word_fifo #(
    .WIDTH (dac_serial_pkg::FRAME_BITS),
    .DEPTH (dac_serial_pkg::FIFO_DEPTH)
  ) u_word_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (r_q.push),
    .in_ready  (fifo_in_ready),
    .in_data   (r_q.push_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready = !apply_hold;

  // ==========================================================================
  // Edge detection and frame field decode
  // ==========================================================================
  assign sclk_fall = r_q.sclk_prev && !sclk_f;
  assign fsel_fall = r_q.fsel_prev && !fsel_n_f;

  assign w_addr = fifo_out_data[dac_serial_pkg::ADDR_MSB:dac_serial_pkg::ADDR_LSB];
  assign w_mode = fifo_out_data[dac_serial_pkg::MODE_MSB:dac_serial_pkg::MODE_LSB];
  assign w_code = fifo_out_data[dac_serial_pkg::CODE_MSB:dac_serial_pkg::CODE_LSB];

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    r_d           = r_q;
    r_d.sclk_prev = sclk_f;
    r_d.fsel_prev = fsel_n_f;
    r_d.push      = 1'b0;
    r_d.wake      = 4'h0;
    r_d.done      = 1'b0;
    r_d.drop      = 1'b0;
    r_d.rdy       = fifo_in_ready;

    // Serial frame receiver.
    unique case (r_q.st)
      dac_serial_pkg::ST_IDLE: begin
        if (fsel_fall) begin
          r_d.st      = dac_serial_pkg::ST_SHIFT;
          r_d.bit_idx = 5'h00;
        end
      end
      dac_serial_pkg::ST_SHIFT: begin
        if (fsel_n_f) begin
          r_d.st = dac_serial_pkg::ST_IDLE;
        end else if (sclk_fall) begin
          r_d.shreg   = {r_q.shreg[14:0], sdata_f};
          r_d.bit_idx = r_q.bit_idx + 5'h01;
          if (r_q.bit_idx == dac_serial_pkg::LAST_BIT_INDEX) begin
            r_d.st   = dac_serial_pkg::ST_DONE;
            r_d.done = 1'b1;
            if (fifo_in_ready) begin
              r_d.push      = 1'b1;
              r_d.push_word = {r_q.shreg[14:0], sdata_f};
            end else begin
              r_d.drop = 1'b1;
            end
          end
        end
      end
      dac_serial_pkg::ST_DONE: begin
        if (fsel_n_f) begin
          r_d.st = dac_serial_pkg::ST_IDLE;
        end
      end
      default: begin
        r_d.st = dac_serial_pkg::ST_IDLE;
      end
    endcase

    // Execution of a buffered frame.
    if (fifo_out_valid && fifo_out_ready) begin
      unique case (w_mode)
        dac_serial_pkg::MODE_WRITE_HOLD: begin
          r_d.hold[w_addr] = w_code;
        end
        dac_serial_pkg::MODE_WRITE_UPDATE: begin
          r_d.hold[w_addr] = w_code;
          r_d.out          = r_d.hold;
          r_d.wake         = r_q.pd;
          r_d.pd           = 4'h0;
        end
        dac_serial_pkg::MODE_WRITE_ALL_UPDATE: begin
          for (int c = 0; c < dac_serial_pkg::CHANNELS; c++) begin
            r_d.hold[c] = w_code;
            r_d.out[c]  = w_code;
          end
          r_d.wake = r_q.pd;
          r_d.pd   = 4'h0;
        end
        dac_serial_pkg::MODE_POWER_DOWN: begin
          r_d.pd = 4'hF;
        end
      endcase
    end

    for (int c = 0; c < dac_serial_pkg::CHANNELS; c++) begin
      r_d.full[c] = (r_d.out[c] == dac_serial_pkg::CODE_FULL);
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r_q           <= '0;
      r_q.st        <= dac_serial_pkg::ST_IDLE;
      r_q.hold      <= {4{dac_serial_pkg::CODE_RESET}};
      r_q.out       <= {4{dac_serial_pkg::CODE_RESET}};
      r_q.sclk_prev <= 1'b0;
      r_q.fsel_prev <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign channel_code_q = r_q.out;
  assign powered_down_q = r_q.pd;
  assign wake_start_q   = r_q.wake;
  assign full_scale_q   = r_q.full;
  assign frame_done_q   = r_q.done;
  assign frame_drop_q   = r_q.drop;
  assign accept_ready_q = r_q.rdy;

endmodule // quad_dac_serial_write_port

/* File: dac_port_checker.sv */
// Assertions on the ports of the quad converter serial write port.
// Assumes one clk_sys domain with synchronous active-high srst.
`timescale 1ns/1ns
module dac_port_checker (
  input wire logic            clk_sys,
  input wire logic            srst,
  input wire logic            sclk,
  input wire logic            frame_sel_n,
  input wire logic            sdata,
  input wire logic            apply_hold,
  input wire logic [3:0][9:0] channel_code_q,
  input wire logic [3:0]      powered_down_q,
  input wire logic [3:0]      wake_start_q,
  input wire logic [3:0]      full_scale_q,
  input wire logic            frame_done_q,
  input wire logic            frame_drop_q,
  input wire logic            accept_ready_q
);
  // ====
  // Sequences and assertions
  // ====
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_idle;
    frame_sel_n [*6];
  endsequence
  sequence s_fall;
    !$past(sclk, 3) && !$past(frame_sel_n, 3);
  endsequence
  AST_DONE_FALL: assert property (frame_done_q |-> s_fall)
    else $error("frame done without a selected clock fall");
  AST_DONE_PULSE: assert property (frame_done_q |=> !frame_done_q)
    else $error("frame done longer than one cycle");
  AST_IDLE: assert property (s_idle |=> !frame_done_q)
    else $error("frame done while not selected");
  AST_FULL: assert property (full_scale_q == {channel_code_q[3] == 10'h3FF,
    channel_code_q[2] == 10'h3FF, channel_code_q[1] == 10'h3FF, channel_code_q[0] == 10'h3FF})
    else $error("full scale flag wrong");
  AST_STALL: assert property (!$stable(channel_code_q) |-> !$past(apply_hold))
    else $error("code changed while held");
  AST_WAKE: assert property (|wake_start_q |->
    wake_start_q == $past(powered_down_q) && powered_down_q == 4'h0)
    else $error("wake start wrong");
  AST_PD_KEEP: assert property ($rose(powered_down_q[0]) |-> $stable(channel_code_q))
    else $error("power down changed codes");
  AST_PD_ALL: assert property (powered_down_q == 4'h0 || powered_down_q == 4'hF)
    else $error("power down not uniform");
  AST_DROP: assert property (frame_drop_q |-> !accept_ready_q)
    else $error("drop while buffer not full");
endmodule // dac_port_checker

bind quad_dac_serial_write_port dac_port_checker chk_u (
  .clk_sys(clk_sys), .srst(srst), .sclk(sclk), .frame_sel_n(frame_sel_n),
  .sdata(sdata), .apply_hold(apply_hold), .channel_code_q(channel_code_q),
  .powered_down_q(powered_down_q), .wake_start_q(wake_start_q),
  .full_scale_q(full_scale_q), .frame_done_q(frame_done_q),
  .frame_drop_q(frame_drop_q), .accept_ready_q(accept_ready_q));

/* File: host_model.sv */
// Host controller model driving the three-wire serial write bus.
// Assumes clk_sys at 25 MHz; one frame per go request while idle.
`timescale 1ns/1ns
module host_model (
  input  wire logic        clk_sys,
  input  wire logic        go,
  input  wire logic [15:0] word,
  input  wire logic [4:0]  n_falls,
  input  wire logic        slow,
  input  wire logic        keep_low,
  output logic             busy = 1'h0,
  output logic             sclk = 1'h1,
  output logic             frame_sel_n = 1'h1,
  output logic             sdata = 1'h0
);
  int hp;
  always @(posedge clk_sys) begin
    if (go && !busy) begin
      hp = slow ? 8 : 4;
      busy <= 1'h1;
      frame_sel_n <= 1'h1;
      repeat (8) @(posedge clk_sys);
      frame_sel_n <= 1'h0;
      for (int i = 0; i < n_falls; i++) begin
        sdata <= word[15 - (i % 16)] ^ (i > 15);
        repeat (hp) @(posedge clk_sys);
        sclk <= 1'h0;
        repeat (hp) @(posedge clk_sys);
        sclk <= 1'h1;
      end
      repeat (hp) @(posedge clk_sys);
      if (!keep_low) begin
        frame_sel_n <= 1'h1;
        repeat (8) @(posedge clk_sys);
      end
      frame_sel_n <= 1'h0;
      sdata <= 1'h0;
      busy <= 1'h0;
    end
  end
endmodule // host_model

/* File: testbench.sv */
// Self-checking testbench for the quad converter serial write port.
// Assumes host_model and the bound checker are compiled before it.
`timescale 1ns/1ns
module testbench;
  logic            clk_sys = 1'h0, srst = 1'h1, apply_hold = 1'h0, go = 1'h0;
  logic [15:0]     word = 16'h0000;
  logic [4:0]      n_falls = 5'h10;
  logic            slow = 1'h0, keep_low = 1'h0;
  logic            busy, sclk, frame_sel_n, sdata, done_p, drop_p, ready;
  logic [3:0][9:0] code;
  logic [3:0]      pd, woke_p, fs;
  logic [3:0]      woke = 4'h0;
  int              n_errors = 0, comparisons = 0, n_done = 0, n_drop = 0;

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  host_model host_u (.clk_sys(clk_sys), .go(go), .word(word), .n_falls(n_falls),
    .slow(slow), .keep_low(keep_low), .busy(busy), .sclk(sclk),
    .frame_sel_n(frame_sel_n), .sdata(sdata));
  quad_dac_serial_write_port dut_u (.clk_sys(clk_sys), .srst(srst), .sclk(sclk),
    .frame_sel_n(frame_sel_n), .sdata(sdata), .apply_hold(apply_hold),
    .channel_code_q(code), .powered_down_q(pd), .wake_start_q(woke_p),
    .full_scale_q(fs), .frame_done_q(done_p), .frame_drop_q(drop_p),
    .accept_ready_q(ready));

  always @(posedge clk_sys) begin
    n_done += int'(done_p === 1'h1);
    n_drop += int'(drop_p === 1'h1);
    woke |= woke_p;
  end

  // ====
  // Shared tasks
  // ====
  task automatic final_report();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  function automatic logic [15:0] fw(logic [1:0] a, logic [1:0] m, logic [9:0] c);
    return {a, m, c, 2'h3};
  endfunction

  task automatic send(input logic [15:0] w, input logic [4:0] n, input logic s,
                      input logic k);
    word <= w;
    n_falls <= n;
    slow <= s;
    keep_low <= k;
    go <= 1'h1;
    @(posedge clk_sys);
    go <= 1'h0;
    for (int i = 0; i <= 4000; i++) begin
      @(posedge clk_sys);
      if (busy === 1'h0) break;
      if (i == 4000) begin
        n_errors++;
        final_report();
      end
    end
    repeat (8) @(posedge clk_sys);
  endtask

  // ====
  // Scenarios
  // ====
  task automatic t_reset();
    chk("code", 40'h0, code);
    chk("pdown", 40'h0, 40'(pd));
    chk("ready", 40'h1, 40'(ready));
  endtask

  task automatic t_update();
    int base;
    base = n_done;
    send(fw(2'h0, dac_serial_pkg::MODE_WRITE_UPDATE, 10'h3FF), 5'h10, 1'h0, 1'h0);
    chk("code", {30'h0, 10'h3FF}, code);
    chk("full", 40'h1, 40'(fs));
    chk("done", 40'h1, 40'(n_done - base));
  endtask

  task automatic t_hold();
    int base;
    base = n_done;
    send(fw(2'h1, dac_serial_pkg::MODE_WRITE_HOLD, 10'h155), 5'h14, 1'h1, 1'h1);
    chk("code", {30'h0, 10'h3FF}, code);
    chk("done", 40'h1, 40'(n_done - base));
    send(fw(2'h2, dac_serial_pkg::MODE_WRITE_UPDATE, 10'h0AA), 5'h10, 1'h0, 1'h0);
    chk("code", {10'h0, 10'h0AA, 10'h155, 10'h3FF}, code);
  endtask

  task automatic t_modes();
    send(fw(2'h3, dac_serial_pkg::MODE_WRITE_ALL_UPDATE, 10'h200), 5'h10, 1'h0, 1'h0);
    chk("code", {4{10'h200}}, code);
    send(fw(2'h0, dac_serial_pkg::MODE_POWER_DOWN, 10'h000), 5'h10, 1'h0, 1'h0);
    chk("pdown", 40'hF, 40'(pd));
    chk("code", {4{10'h200}}, code);
    chk("wake", 40'h0, 40'(woke));
    send(fw(2'h3, dac_serial_pkg::MODE_WRITE_UPDATE, 10'h3FF), 5'h10, 1'h0, 1'h0);
    chk("code", {10'h3FF, {3{10'h200}}}, code);
    chk("pdown", 40'h0, 40'(pd));
    chk("wake", 40'hF, 40'(woke));
    chk("full", 40'h8, 40'(fs));
  endtask

  task automatic t_abort();
    int base;
    base = n_done;
    send(fw(2'h1, dac_serial_pkg::MODE_WRITE_UPDATE, 10'h111), 5'h08, 1'h0, 1'h0);
    chk("done", 40'h0, 40'(n_done - base));
    chk("code", {10'h3FF, {3{10'h200}}}, code);
  endtask

  task automatic t_fifo();
    int base;
    base = n_drop;
    chk("drop", 40'h0, 40'(n_drop));
    apply_hold <= 1'h1;
    for (int i = 0; i < 17; i++) begin
      send(fw(2'h3, dac_serial_pkg::MODE_WRITE_UPDATE, 10'(i)), 5'h10, 1'h0, 1'h0);
    end
    chk("drop", 40'h1, 40'(n_drop - base));
    chk("ready", 40'h0, 40'(ready));
    chk("code", {10'h3FF, {3{10'h200}}}, code);
    apply_hold <= 1'h0;
    repeat (60) @(posedge clk_sys);
    chk("code", {10'h00F, {3{10'h200}}}, code);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'h0;
    repeat (8) @(posedge clk_sys);
    t_reset();
    t_update();
    t_hold();
    t_modes();
    t_abort();
    t_fifo();
    final_report();
  end
endmodule // testbench
